// ==== verilog/cps_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
module cps_sequencer #(
    parameter int MS_CYCLES = cps_pkg::CPS_MS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire cps_pkg::cps_bus_req_s bus_req,
    output logic [cps_pkg::CPS_DW-1:0] bus_rdata,
    input wire logic [cps_pkg::CPS_NDIG-1:0] dig_in,
    input wire logic [cps_pkg::CPS_NAUX-1:0] aux_pwm,
    output logic [cps_pkg::CPS_NOUT-1:0] inj_cmd,
    output logic sequence_active,
    output logic [cps_pkg::CPS_CNTW-1:0] pulses_delivered
);

    // ======================================================================
    // derived constants
    localparam logic [cps_pkg::CPS_PREW-1:0] PRE_LAST =
        cps_pkg::CPS_PREW'(MS_CYCLES - 1);
    localparam logic [cps_pkg::CPS_CNTW-1:0] ONE =
        cps_pkg::CPS_CNTW'(1);

    // ======================================================================
    // state
    cps_pkg::cps_state_s s_r;
    cps_pkg::cps_state_s s_nxt;

    logic [cps_pkg::CPS_NDIG-1:0] dig_sync;
    logic [cps_pkg::CPS_NSRC-1:0] trig_src;
    logic trig_level;
    logic trig_rise;
    logic sequence_launch;
    logic pulse_count_clear;
    logic ms_tick;
    logic [cps_pkg::CPS_CNTW-1:0] ms_next;
    logic [cps_pkg::CPS_CNTW-1:0] count_base;
    logic [cps_pkg::CPS_CNTW-1:0] count_after;
    logic start_req;
    logic [cps_pkg::CPS_NOUT-1:0] chan_gate;

    // ======================================================================
    // trigger inputs
    cps_sync #(
        .W(cps_pkg::CPS_NDIG)
    ) u_dig_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(dig_in),
        .sync_out(dig_sync)
    );

    // index zero stands for no source
    assign trig_src = {aux_pwm, dig_sync, 1'b0};

    always_comb begin
        trig_level = 1'b0;
        if (int'(s_r.trig_sel) < cps_pkg::CPS_NSRC) begin
            trig_level = trig_src[s_r.trig_sel];
        end
    end

    assign trig_rise = trig_level & ~s_r.trig_prev;

    // ======================================================================
    // register writes, reads and sequencing
    always_comb begin
        logic [cps_pkg::CPS_NCH-1:0] en;
        logic single;
        en = '0;
        single = 1'b0;
        chan_gate = '0;
        s_nxt = s_r;
        s_nxt.rdata = '0;
        sequence_launch = 1'b0;
        pulse_count_clear = 1'b0;

        // register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                cps_pkg::CPS_OFS_CTRL: begin
                    sequence_launch =
                        bus_req.wdata[cps_pkg::CPS_CTRL_LAUNCH];
                    s_nxt.hold = bus_req.wdata[cps_pkg::CPS_CTRL_HOLD];
                    pulse_count_clear =
                        bus_req.wdata[cps_pkg::CPS_CTRL_CLEAR];
                    s_nxt.ext_en = bus_req.wdata[cps_pkg::CPS_CTRL_EXT_EN];
                end
                cps_pkg::CPS_OFS_WIDTH: begin
                    s_nxt.width_ms = bus_req.wdata[cps_pkg::CPS_CNTW-1:0];
                end
                cps_pkg::CPS_OFS_INTERVAL: begin
                    s_nxt.interval_ms =
                        bus_req.wdata[cps_pkg::CPS_CNTW-1:0];
                end
                cps_pkg::CPS_OFS_TOTAL: begin
                    s_nxt.total = bus_req.wdata[cps_pkg::CPS_CNTW-1:0];
                end
                cps_pkg::CPS_OFS_TRIG_SEL: begin
                    s_nxt.trig_sel = bus_req.wdata[cps_pkg::CPS_SELW-1:0];
                end
                cps_pkg::CPS_OFS_CAL_MODE: begin
                    s_nxt.cal_mode = bus_req.wdata[cps_pkg::CPS_NMOD-1:0];
                end
                cps_pkg::CPS_OFS_CHAN_EN: begin
                    s_nxt.chan_en = bus_req.wdata[cps_pkg::CPS_NOUT-1:0];
                end
                default: begin
                end
            endcase
        end

        // register reads, answered in the next cycle only
        if (bus_req.rd) begin
            case (bus_req.addr)
                cps_pkg::CPS_OFS_CTRL: begin
                    s_nxt.rdata[cps_pkg::CPS_CTRL_HOLD] = s_r.hold;
                    s_nxt.rdata[cps_pkg::CPS_CTRL_EXT_EN] = s_r.ext_en;
                end
                cps_pkg::CPS_OFS_WIDTH: begin
                    s_nxt.rdata[cps_pkg::CPS_CNTW-1:0] = s_r.width_ms;
                end
                cps_pkg::CPS_OFS_INTERVAL: begin
                    s_nxt.rdata[cps_pkg::CPS_CNTW-1:0] = s_r.interval_ms;
                end
                cps_pkg::CPS_OFS_TOTAL: begin
                    s_nxt.rdata[cps_pkg::CPS_CNTW-1:0] = s_r.total;
                end
                cps_pkg::CPS_OFS_TRIG_SEL: begin
                    s_nxt.rdata[cps_pkg::CPS_SELW-1:0] = s_r.trig_sel;
                end
                cps_pkg::CPS_OFS_CAL_MODE: begin
                    s_nxt.rdata[cps_pkg::CPS_NMOD-1:0] = s_r.cal_mode;
                end
                cps_pkg::CPS_OFS_CHAN_EN: begin
                    s_nxt.rdata[cps_pkg::CPS_NOUT-1:0] = s_r.chan_en;
                end
                cps_pkg::CPS_OFS_STATUS: begin
                    s_nxt.rdata[cps_pkg::CPS_STAT_ACTIVE] = s_r.active;
                    s_nxt.rdata[cps_pkg::CPS_STAT_WAITING] =
                        (s_r.phase == cps_pkg::CPS_WAIT);
                    s_nxt.rdata[cps_pkg::CPS_STAT_PULSE] =
                        (s_r.phase == cps_pkg::CPS_HIGH);
                end
                cps_pkg::CPS_OFS_DELIVERED: begin
                    s_nxt.rdata[cps_pkg::CPS_CNTW-1:0] = s_r.delivered;
                end
                default: begin
                end
            endcase
        end

        // millisecond time base, restarted each time a pulse starts
        ms_tick = (s_r.pre == PRE_LAST);
        s_nxt.pre = ms_tick ? '0 : s_r.pre + 1'b1;
        ms_next = s_r.ms_cnt + (ms_tick ? ONE : '0);
        s_nxt.ms_cnt = ms_next;

        // external trigger edge tracking
        s_nxt.trig_prev = trig_level;
        start_req = sequence_launch
            | (s_r.ext_en & trig_rise);

        // a clear that meets a completing pulse still counts that pulse
        count_base = pulse_count_clear ? '0 : s_r.delivered;
        count_after = count_base + ONE;
        s_nxt.delivered = count_base;

        case (s_r.phase)
            cps_pkg::CPS_IDLE: begin
                // starts are honoured only while idle
                if (start_req && (s_r.total != '0)) begin
                    if (count_base >= s_r.total) begin
                        s_nxt.delivered = '0;
                    end
                    if (s_nxt.hold) begin
                        s_nxt.phase = cps_pkg::CPS_WAIT;
                    end else begin
                        s_nxt.phase = cps_pkg::CPS_HIGH;
                        s_nxt.pre = '0;
                        s_nxt.ms_cnt = '0;
                    end
                end
            end
            cps_pkg::CPS_HIGH: begin
                // hold is ignored here so the pulse runs full width
                if (ms_next >= s_r.width_ms) begin
                    s_nxt.delivered = count_after;
                    if (count_after >= s_r.total) begin
                        s_nxt.phase = cps_pkg::CPS_IDLE;
                    end else begin
                        s_nxt.phase = cps_pkg::CPS_LOW;
                    end
                end
            end
            cps_pkg::CPS_LOW: begin
                if (ms_next >= s_r.interval_ms) begin
                    if (s_nxt.hold) begin
                        s_nxt.phase = cps_pkg::CPS_WAIT;
                    end else begin
                        s_nxt.phase = cps_pkg::CPS_HIGH;
                        s_nxt.pre = '0;
                        s_nxt.ms_cnt = '0;
                    end
                end
            end
            cps_pkg::CPS_WAIT: begin
                // resume at the kept pulse position
                if (!s_nxt.hold) begin
                    s_nxt.phase = cps_pkg::CPS_HIGH;
                    s_nxt.pre = '0;
                    s_nxt.ms_cnt = '0;
                end
            end
            default: begin
                s_nxt.phase = cps_pkg::CPS_IDLE;
            end
        endcase

        // channel gating per driver module, on the new settings
        for (int m = 0; m < cps_pkg::CPS_NMOD; m++) begin
            en = s_nxt.chan_en[m*cps_pkg::CPS_NCH +: cps_pkg::CPS_NCH];
            single = (en != '0) && ((en & (en - 1'b1)) == '0);
            if (single && s_nxt.cal_mode[m]) begin
                chan_gate[m*cps_pkg::CPS_NCH +: cps_pkg::CPS_NCH] = en;
            end
        end

        s_nxt.active = (s_nxt.phase != cps_pkg::CPS_IDLE);
        s_nxt.inj_cmd = (s_nxt.phase == cps_pkg::CPS_HIGH)
            ? chan_gate : '0;
    end

    // ======================================================================
    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r.phase <= cps_pkg::CPS_IDLE;
            s_r.hold <= 1'b0;
            s_r.ext_en <= 1'b0;
            s_r.width_ms <= cps_pkg::CPS_RST_WIDTH;
            s_r.interval_ms <= cps_pkg::CPS_RST_INTERVAL;
            s_r.total <= cps_pkg::CPS_RST_TOTAL;
            s_r.trig_sel <= cps_pkg::CPS_RST_TRIG_SEL;
            s_r.cal_mode <= cps_pkg::CPS_RST_CAL_MODE;
            s_r.chan_en <= cps_pkg::CPS_RST_CHAN_EN;
            s_r.delivered <= '0;
            s_r.pre <= '0;
            s_r.ms_cnt <= '0;
            s_r.trig_prev <= 1'b0;
            s_r.inj_cmd <= '0;
            s_r.active <= 1'b0;
            s_r.rdata <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // outputs
    assign bus_rdata = s_r.rdata;
    assign inj_cmd = s_r.inj_cmd;
    assign sequence_active = s_r.active;
    assign pulses_delivered = s_r.delivered;

endmodule : cps_sequencer
`default_nettype wire

// ==== inc/cps_pkg.sv ====
// ==========================================================================
// calibration pulse sequencer shared constants and types
package cps_pkg;

    // ======================================================================
    // sizes
    localparam int CPS_AW = 8;
    localparam int CPS_DW = 32;
    localparam int CPS_NMOD = 4;
    localparam int CPS_NCH = 4;
    localparam int CPS_NOUT = CPS_NMOD * CPS_NCH;
    localparam int CPS_NDIG = 12;
    localparam int CPS_NAUX = 4;
    localparam int CPS_NSRC = CPS_NDIG + CPS_NAUX + 1;
    localparam int CPS_SELW = 5;
    localparam int CPS_CNTW = 16;
    localparam int CPS_PREW = 15;

    // ======================================================================
    // timing
    localparam int CPS_CLK_PERIOD_NS = 40;
    localparam int CPS_MS_NS = 1000000;
    localparam int CPS_MS_CYCLES = CPS_MS_NS / CPS_CLK_PERIOD_NS;

    // ======================================================================
    // register offsets
    localparam logic [7:0] CPS_OFS_CTRL = 8'h00;
    localparam logic [7:0] CPS_OFS_WIDTH = 8'h04;
    localparam logic [7:0] CPS_OFS_INTERVAL = 8'h08;
    localparam logic [7:0] CPS_OFS_TOTAL = 8'h0C;
    localparam logic [7:0] CPS_OFS_TRIG_SEL = 8'h10;
    localparam logic [7:0] CPS_OFS_CAL_MODE = 8'h14;
    localparam logic [7:0] CPS_OFS_CHAN_EN = 8'h18;
    localparam logic [7:0] CPS_OFS_STATUS = 8'h1C;
    localparam logic [7:0] CPS_OFS_DELIVERED = 8'h20;

    // ======================================================================
    // field positions
    localparam int CPS_CTRL_LAUNCH = 0;
    localparam int CPS_CTRL_HOLD = 1;
    localparam int CPS_CTRL_CLEAR = 2;
    localparam int CPS_CTRL_EXT_EN = 3;
    localparam int CPS_STAT_ACTIVE = 0;
    localparam int CPS_STAT_WAITING = 1;
    localparam int CPS_STAT_PULSE = 2;

    // ======================================================================
    // values after reset
    localparam logic [15:0] CPS_RST_WIDTH = 16'h0001;
    localparam logic [15:0] CPS_RST_INTERVAL = 16'h0002;
    localparam logic [15:0] CPS_RST_TOTAL = 16'h0001;
    localparam logic [4:0] CPS_RST_TRIG_SEL = 5'h00;
    localparam logic [3:0] CPS_RST_CAL_MODE = 4'h0;
    localparam logic [15:0] CPS_RST_CHAN_EN = 16'h0000;

    // ======================================================================
    // types
    typedef enum logic [1:0] {
        CPS_IDLE,
        CPS_HIGH,
        CPS_LOW,
        CPS_WAIT
    } cps_phase_e;

    typedef struct packed {
        logic [CPS_AW-1:0] addr;
        logic [CPS_DW-1:0] wdata;
        logic wr;
        logic rd;
    } cps_bus_req_s;

    typedef struct packed {
        cps_phase_e phase;
        logic hold;
        logic ext_en;
        logic [CPS_CNTW-1:0] width_ms;
        logic [CPS_CNTW-1:0] interval_ms;
        logic [CPS_CNTW-1:0] total;
        logic [CPS_SELW-1:0] trig_sel;
        logic [CPS_NMOD-1:0] cal_mode;
        logic [CPS_NOUT-1:0] chan_en;
        logic [CPS_CNTW-1:0] delivered;
        logic [CPS_PREW-1:0] pre;
        logic [CPS_CNTW-1:0] ms_cnt;
        logic trig_prev;
        logic [CPS_NOUT-1:0] inj_cmd;
        logic active;
        logic [CPS_DW-1:0] rdata;
    } cps_state_s;

endpackage : cps_pkg

// ==== verilog/cps_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// two flip-flop synchroniser for a group of levels
module cps_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } cps_sync_s;

    cps_sync_s s_r;
    cps_sync_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.stage1 = async_in;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.stage2;

endmodule : cps_sync
`default_nettype wire

// ==== tb/cps_sequencer_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// port checks for the pulse sequencer
module cps_checker #(
    parameter int MS_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire cps_pkg::cps_bus_req_s bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic [11:0] dig_in,
    input wire logic [3:0] aux_pwm,
    input wire logic [15:0] inj_cmd,
    input wire logic sequence_active,
    input wire logic [15:0] pulses_delivered
);
    logic [15:0] width_r, interval_r, total_r, chan_r;
    logic [3:0] cal_r, bad_grp, uncal;
    logic hold_r, hold_seen_r, prev_r, any_cmd, wr_ctrl;
    logic ext_r, wr_launch;
    int hi_cnt, gap_cnt;

    assign any_cmd = |inj_cmd;
    assign wr_ctrl = bus_req.wr && bus_req.addr == 8'h00;
    assign wr_launch = wr_ctrl && bus_req.wdata[0];

    always_comb begin
        for (int m = 0; m < 4; m++) begin
            bad_grp[m] = |inj_cmd[m*4+:4] && (!$onehot(chan_r[m*4+:4])
                || inj_cmd[m*4+:4] != chan_r[m*4+:4]);
            uncal[m] = |inj_cmd[m*4+:4] && !cal_r[m];
        end
    end

    // shadow of the settings, taken from the write strobes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            width_r <= 16'h0001;
            interval_r <= 16'h0002;
            total_r <= 16'h0001;
            chan_r <= 16'h0000;
            cal_r <= 4'h0;
            hold_r <= 1'b0;
            ext_r <= 1'b0;
            hold_seen_r <= 1'b0;
            prev_r <= 1'b0;
            hi_cnt <= 0;
            gap_cnt <= 0;
        end else begin
            prev_r <= any_cmd;
            hi_cnt <= any_cmd ? hi_cnt + 1 : 0;
            gap_cnt <= (any_cmd && !prev_r) ? 1 : gap_cnt + 1;
            hold_seen_r <= sequence_active && (hold_seen_r || hold_r);
            if (bus_req.wr) begin
                case (bus_req.addr)
                    8'h00: begin
                        hold_r <= bus_req.wdata[1];
                        ext_r <= bus_req.wdata[3];
                    end
                    8'h04: width_r <= bus_req.wdata[15:0];
                    8'h08: interval_r <= bus_req.wdata[15:0];
                    8'h0C: total_r <= bus_req.wdata[15:0];
                    8'h14: cal_r <= bus_req.wdata[3:0];
                    8'h18: chan_r <= bus_req.wdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_RDATA_IDLE: assert property (!$past(bus_req.rd)
        |-> bus_rdata == 32'h0)
        else $error("read data outside answer cycle");
    AST_CMD_IN_RUN: assert property (any_cmd |-> sequence_active)
        else $error("command while not running");
    AST_ONE_CHANNEL: assert property (bad_grp == 4'h0)
        else $error("command to module without single channel");
    AST_CAL_ONLY: assert property (uncal == 4'h0)
        else $error("command to module not in calibration");
    AST_LAUNCH: assert property (wr_ctrl && bus_req.wdata[0]
        && !bus_req.wdata[1] && !sequence_active && total_r != 16'h0
        |=> sequence_active && any_cmd) else $error("launch not answered");
    AST_WIDTH: assert property ($fell(any_cmd)
        |-> hi_cnt == width_r * MS_CYCLES)
        else $error("pulse width wrong");
    AST_PERIOD: assert property ($rose(any_cmd)
        && $past(sequence_active) && !hold_seen_r && !hold_r
        |-> gap_cnt == interval_r * MS_CYCLES)
        else $error("pulse spacing wrong");
    AST_HOLD_BLOCKS: assert property ($rose(any_cmd) |-> !hold_r)
        else $error("pulse started while held");
    AST_DONE_COUNT: assert property ($fell(sequence_active)
        |-> pulses_delivered == total_r && !any_cmd)
        else $error("end count wrong");
    AST_EXT_GATED: assert property ($rose(sequence_active)
        |-> $past(wr_launch) || $past(ext_r))
        else $error("start without launch or enabled trigger");
    AST_COUNT_STEP: assert property ($changed(pulses_delivered)
        |-> pulses_delivered <= 16'h1
        || pulses_delivered == $past(pulses_delivered) + 16'h1)
        else $error("delivered count jumped");
endmodule : cps_checker

bind cps_sequencer cps_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .dig_in(dig_in),
    .aux_pwm(aux_pwm),
    .inj_cmd(inj_cmd),
    .sequence_active(sequence_active),
    .pulses_delivered(pulses_delivered)
);
`default_nettype wire

// ==== tb/cps_ext_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// trigger sources and injector channels on the far side
module cps_ext_model (
    input wire logic ref_clk,
    input wire logic [15:0] inj_cmd,
    output logic [11:0] dig_in,
    output logic [3:0] aux_pwm,
    output logic [15:0] pulses_seen
);
    logic [15:0] lines_r = 16'h0000;
    logic [15:0] prev_cmd = 16'h0000;

    assign {aux_pwm, dig_in} = lines_r;
    initial pulses_seen = 16'h0000;

    // every rising edge on any channel is one delivered pulse
    always @(posedge ref_clk) begin
        pulses_seen <= pulses_seen + 16'($countones(inj_cmd & ~prev_cmd));
        prev_cmd <= inj_cmd;
    end

    task automatic pulse_line(input int line);
        @(posedge ref_clk);
        lines_r[line] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        lines_r[line] <= 1'b0;
    endtask : pulse_line
endmodule : cps_ext_model
`default_nettype wire

// ==== tb/cps_sequencer_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module cps_sequencer_tb_top;
    localparam logic [7:0] RA [9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h1C, 8'h20, 8'h24};
    localparam logic [31:0] RV [9] = '{1, 2, 1, 0, 0, 0, 0, 0, 0};
    localparam logic [31:0] SEL [6] = '{1, 12, 13, 16, 0, 17};
    localparam int LINE [6] = '{0, 11, 12, 15, 0, 15};
    localparam logic [31:0] HIT [6] = '{2, 2, 2, 2, 0, 0};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    cps_pkg::cps_bus_req_s bus_req = '0;
    logic [31:0] bus_rdata, exp_seen;
    logic [11:0] dig_in;
    logic [3:0] aux_pwm;
    logic [15:0] inj_cmd, pulses_delivered, pulses_seen;
    logic sequence_active;
    int fails = 0;
    int cmp_count = 0;

    always #20 ref_clk = ~ref_clk;

    cps_sequencer #(.MS_CYCLES(4)) u_dut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .dig_in(dig_in),
        .aux_pwm(aux_pwm),
        .inj_cmd(inj_cmd),
        .sequence_active(sequence_active),
        .pulses_delivered(pulses_delivered)
    );

    cps_ext_model u_ext (
        .ref_clk(ref_clk),
        .inj_cmd(inj_cmd),
        .dig_in(dig_in),
        .aux_pwm(aux_pwm),
        .pulses_seen(pulses_seen)
    );

    // ======================================================================
    // access tasks
    task automatic chk(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, logic [31:0] e);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 chk(name, bus_rdata, e);
    endtask : rd

    task automatic wait_idle;
        #1;
        for (int i = 0; i < 300 && sequence_active !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_idle

    task automatic end_sim;
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // ======================================================================
    // tests
    initial begin
        #(40 * 4000);
        fails++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd("reset value", RA[i], RV[i]);
        wr(8'h0C, 3);
        wr(8'h14, 32'hB);
        wr(8'h18, 32'h8431);
        wr(8'h00, 1);
        @(posedge ref_clk);
        #1 chk("inj_cmd", inj_cmd, 32'h8001);
        chk("active", sequence_active, 1);
        wr(8'h00, 1);
        wait_idle();
        chk("delivered", pulses_delivered, 3);
        chk("pulses", pulses_seen, 6);
        wr(8'h00, 1);
        wr(8'h00, 2);
        repeat (12) @(posedge ref_clk);
        rd("status held", 8'h1C, 3);
        chk("held count", pulses_delivered, 1);
        wr(8'h00, 0);
        wait_idle();
        chk("resumed pulses", pulses_seen, 12);
        wr(8'h00, 4);
        rd("cleared", 8'h20, 0);
        wr(8'h0C, 1);
        wr(8'h10, 1);
        u_ext.pulse_line(0);
        repeat (12) @(posedge ref_clk);
        #1 chk("ext disabled", pulses_seen, 12);
        wr(8'h00, 8);
        exp_seen = 12;
        for (int i = 0; i < 6; i++) begin
            wr(8'h10, SEL[i]);
            u_ext.pulse_line(LINE[i]);
            repeat (12) @(posedge ref_clk);
            exp_seen = exp_seen + HIT[i];
            #1 chk("ext launch", pulses_seen, exp_seen);
        end
        end_sim();
    end
endmodule : cps_sequencer_tb_top
`default_nettype wire
